// >>> cmr_mode_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "cmr_cfg.svh"

// Behaviour
// - Bits seven and six read zero and ignore writes.
// - Bits three and two read zero and ignore writes.
// - Bit five enables interrupts on rising comparator output edges.
// - Bit four enables interrupts on falling comparator output edges.
// - Bits one and zero hold the response-time selector driven to the comparator.
module cmr_mode_ctrl #(
    parameter int NUM_CMP = 3
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // Register port
    input wire cmr_pkg::cmr_bus_req_t busReq,
    output logic [7:0] rdData,
    // Comparator side
    input wire logic [NUM_CMP-1:0] cmpOut,
    output logic [2*NUM_CMP-1:0] respTimeSel,
    // Events and interrupt
    output logic [NUM_CMP-1:0] riseEvent,
    output logic [NUM_CMP-1:0] fallEvent,
    output logic irq
);
    import cmr_pkg::*;

    localparam int SW = 2 * NUM_CMP;
    localparam int IW = (NUM_CMP > 1) ? $clog2(NUM_CMP) : 1;

    // Status and mask are one byte each at two bits per comparator, so at most four comparators fit
    logic [7:0] modeReg [NUM_CMP];
    logic [SW-1:0] statusReg;
    logic [SW-1:0] statusNext;
    logic [SW-1:0] maskReg;
    logic [SW-1:0] maskNext;
    logic [7:0] rdData_reg;
    logic [7:0] rdDataNext;
    logic irq_reg;
    logic [SW-1:0] respTimeSel_reg;
    logic [NUM_CMP-1:0] riseEvent_reg;
    logic [NUM_CMP-1:0] fallEvent_reg;

    // Synchroniser and edge detector state
    logic [NUM_CMP-1:0] syncMeta_reg;
    logic [NUM_CMP-1:0] syncLevel_reg;
    logic [NUM_CMP-1:0] prevLevel_reg;

    // Address decode
    wire isModeAddr = (busReq.addr >= `CMR_MODE_BASE)
        && (busReq.addr < (`CMR_MODE_BASE + 8'(NUM_CMP)));
    wire [7:0] modeOfs = busReq.addr - `CMR_MODE_BASE;
    wire [IW-1:0] modeIdx = modeOfs[IW-1:0];
    wire isStatusAddr = (busReq.addr == `CMR_STATUS_ADDR);
    wire isMaskAddr = (busReq.addr == `CMR_MASK_ADDR);
    wire isLevelAddr = (busReq.addr == `CMR_LEVEL_ADDR);
    wire wrMask = busReq.wrStb && isMaskAddr;
    wire rdStatus = busReq.rdStb && isStatusAddr;

    // Writes keep only the defined fields
    wire [7:0] modeWrVal = busReq.wrData & `CMR_MODE_WMASK;

    // Edge detection on the synchronised level
    wire [NUM_CMP-1:0] riseRaw = syncLevel_reg & ~prevLevel_reg;
    wire [NUM_CMP-1:0] fallRaw = ~syncLevel_reg & prevLevel_reg;

    // Enable gating per comparator
    wire [SW-1:0] statusSet;
    wire [NUM_CMP-1:0] riseGated;
    wire [NUM_CMP-1:0] fallGated;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CMP; gi++) begin : g_cmp
            wire riseEn = modeReg[gi][`CMR_RISE_EN_BIT];
            wire fallEn = modeReg[gi][`CMR_FALL_EN_BIT];
            wire modeWr = busReq.wrStb && isModeAddr && (modeIdx == IW'(gi));

            assign riseGated[gi] = riseRaw[gi] && riseEn;
            assign fallGated[gi] = fallRaw[gi] && fallEn;
            assign statusSet[2*gi+`CMR_EVT_RISE_OFS] = riseGated[gi];
            assign statusSet[2*gi+`CMR_EVT_FALL_OFS] = fallGated[gi];

            always_ff @(posedge clk_sys or negedge rstn) begin
                if (!rstn) begin
                    modeReg[gi] <= `CMR_MODE_RST;
                end else if (modeWr) begin
                    modeReg[gi] <= modeWrVal;
                end
            end

            always_ff @(posedge clk_sys or negedge rstn) begin
                if (!rstn) begin
                    respTimeSel_reg[2*gi+1:2*gi] <= CMR_RESP_MODE0;
                end else begin
                    respTimeSel_reg[2*gi+1:2*gi] <=
                        modeReg[gi][`CMR_RESP_SEL_MSB:`CMR_RESP_SEL_LSB];
                end
            end
        end
    endgenerate

    // A new event in the clearing read's cycle survives the clear
    assign statusNext = rdStatus ? statusSet : (statusReg | statusSet);
    assign maskNext = wrMask ? busReq.wrData[SW-1:0] : maskReg;

    // Read selection; unmapped addresses read zero
    wire [7:0] modeRdVal = isModeAddr ? modeReg[modeIdx] : 8'h00;
    wire [7:0] statusRdVal = isStatusAddr ? 8'(statusReg) : 8'h00;
    wire [7:0] maskRdVal = isMaskAddr ? 8'(maskReg) : 8'h00;
    wire [7:0] levelRdVal = isLevelAddr ? 8'(syncLevel_reg) : 8'h00;
    assign rdDataNext = busReq.rdStb
        ? (modeRdVal | statusRdVal | maskRdVal | levelRdVal) : 8'h00;

    // First stage feeds only the second stage
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            syncMeta_reg <= '0;
            syncLevel_reg <= '0;
            prevLevel_reg <= '0;
        end else begin
            syncMeta_reg <= cmpOut;
            syncLevel_reg <= syncMeta_reg;
            prevLevel_reg <= syncLevel_reg;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            statusReg <= SW'(`CMR_STATUS_RST);
            maskReg <= SW'(`CMR_MASK_RST);
        end else begin
            statusReg <= statusNext;
            maskReg <= maskNext;
        end
    end

    // Interrupt is registered from the next status and mask, so it changes with status and the output is a flop
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(statusNext & maskNext);
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            riseEvent_reg <= '0;
            fallEvent_reg <= '0;
            rdData_reg <= 8'h00;
        end else begin
            riseEvent_reg <= riseGated;
            fallEvent_reg <= fallGated;
            rdData_reg <= rdDataNext;
        end
    end

    assign rdData = rdData_reg;
    assign irq = irq_reg;
    assign respTimeSel = respTimeSel_reg;
    assign riseEvent = riseEvent_reg;
    assign fallEvent = fallEvent_reg;

endmodule : cmr_mode_ctrl
`default_nettype wire

// >>> cmr_cfg.svh
`ifndef CMR_CFG_SVH
`define CMR_CFG_SVH

// Register byte addresses on the plain register port
`define CMR_MODE_BASE 8'h00
`define CMR_STATUS_ADDR 8'h10
`define CMR_MASK_ADDR 8'h11
`define CMR_LEVEL_ADDR 8'h12

// Mode control field positions
`define CMR_RISE_EN_BIT 5
`define CMR_FALL_EN_BIT 4
`define CMR_RESP_SEL_LSB 0
`define CMR_RESP_SEL_MSB 1

// Only bits 5, 4, 1 and 0 are stored
`define CMR_MODE_WMASK 8'h33

// Reset values
`define CMR_MODE_RST 8'h00
`define CMR_MASK_RST 8'h00
`define CMR_STATUS_RST 8'h00

// Status and mask layout: two bits per comparator
`define CMR_EVT_RISE_OFS 0
`define CMR_EVT_FALL_OFS 1

`endif

// >>> cmr_pkg.sv
`default_nettype none
package cmr_pkg;

    // One access on the register port
    typedef struct packed {
        logic wrStb;
        logic rdStb;
        logic [7:0] addr;
        logic [7:0] wrData;
    } cmr_bus_req_t;

    // Edge events of one comparator
    typedef struct packed {
        logic fall;
        logic rise;
    } cmr_edge_t;

    // Response-time selector codes
    typedef enum logic [1:0] {
        CMR_RESP_MODE0 = 2'b00,
        CMR_RESP_MODE1 = 2'b01,
        CMR_RESP_MODE2 = 2'b10,
        CMR_RESP_MODE3 = 2'b11
    } cmr_resp_sel_t;

endpackage : cmr_pkg
`default_nettype wire

// >>> cmr_mode_ctrl_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module cmr_mode_ctrl_monitor import cmr_pkg::*; #(parameter int NUM_CMP = 3) (
    // Clock
    input wire logic clk_sys,
    input wire logic rstn,
    // Bus
    input wire cmr_pkg::cmr_bus_req_t busReq,
    input wire logic [7:0] rdData,
    // Comparator
    input wire logic [NUM_CMP-1:0] cmpOut,
    input wire logic [2*NUM_CMP-1:0] respTimeSel,
    input wire logic [NUM_CMP-1:0] riseEvent,
    input wire logic [NUM_CMP-1:0] fallEvent,
    input wire logic irq
);
    logic [7:0] mode_reg;
    wire logic wrMode = busReq.wrStb && busReq.addr == 8'h00;
    wire logic rdMode = busReq.rdStb && busReq.addr < 8'(NUM_CMP);
    // Shadow of mode 0, so gating is judged without peeking inside
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            mode_reg <= 8'h00;
        end else if (wrMode) begin
            mode_reg <= busReq.wrData & 8'h33;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    sequence quietMode;
        !wrMode [*3];
    endsequence
    hi_bits_zero_a: assert property (rdMode |=> rdData[7:6] == 2'b00)
        else $error("mode bits 7-6 not zero");
    mid_bits_zero_a: assert property (rdMode |=> rdData[3:2] == 2'b00)
        else $error("mode bits 3-2 not zero");
    // The event flop lags the gate by one cycle, so judge the enable of that cycle
    rise_gate_a: assert property (riseEvent[0] |-> $past(mode_reg[5]))
        else $error("rise event while disabled");
    fall_gate_a: assert property (fallEvent[0] |-> $past(mode_reg[4]))
        else $error("fall event while disabled");
    resp_sel_a: assert property (quietMode |-> respTimeSel[1:0] == mode_reg[1:0])
        else $error("selector differs from mode");
    rise_pulse_a: assert property (riseEvent[0] |=> !riseEvent[0])
        else $error("rise event longer than a cycle");
endmodule : cmr_mode_ctrl_monitor
bind cmr_mode_ctrl cmr_mode_ctrl_monitor #(.NUM_CMP(NUM_CMP)) mon (.clk_sys, .rstn, .busReq,
    .rdData, .cmpOut, .respTimeSel, .riseEvent, .fallEvent, .irq);
`default_nettype wire

// >>> comparator_mode_register_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module comparator_mode_register_tb_top;
    import cmr_pkg::*;
    logic clk_sys, rstn, irq;
    cmr_bus_req_t busReq;
    logic [7:0] rdData;
    logic [2:0] cmpOut, riseEvent, fallEvent;
    logic [5:0] respTimeSel;
    int bad_count = 0;
    int tests_run = 0;
    cmr_mode_ctrl #(.NUM_CMP(3)) DUT (.clk_sys, .rstn, .busReq, .rdData, .cmpOut,
        .respTimeSel, .riseEvent, .fallEvent, .irq);
    initial begin
        clk_sys = 0;
        forever #4 clk_sys = ~clk_sys;
    end
    task automatic check(string n, logic [7:0] e, logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask : check
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk_sys);
        busReq <= '{1'b1, 1'b0, a, d};
        @(posedge clk_sys);
        busReq <= '0;
    endtask : wr
    task automatic rd(logic [7:0] a, logic [7:0] e);
        @(posedge clk_sys);
        busReq <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk_sys);
        busReq <= '0;
        #1 check("rdData", e, rdData);
    endtask : rd
    task automatic regs_scn;
        for (int i = 0; i < 3; i++) begin
            wr(8'(i), 8'hFF);
            rd(8'(i), 8'h33);
        end
        rd(8'h05, 8'h00);
    endtask : regs_scn
    task automatic sel_scn;
        for (int m = 0; m < 4; m++) begin
            wr(8'h01, 8'hCC | 8'(m));
            repeat (3) @(posedge clk_sys);
            #1 check("sel", 8'(m), 8'(respTimeSel[3:2]));
        end
        check("selAll", 8'h3F, 8'(respTimeSel));
    endtask : sel_scn
    // Waits a fixed span: the edge path is three flops deep, eight leaves margin
    task automatic edge_scn(logic v, logic [7:0] en, int r, int f, logic [7:0] st, logic q);
        int nr = 0;
        int nf = 0;
        wr(8'h00, en);
        cmpOut <= {2'b00, v};
        repeat (8) begin
            @(posedge clk_sys);
            #1 nr += riseEvent[0];
            nf += fallEvent[0];
        end
        check("rise", 8'(r), 8'(nr));
        check("fall", 8'(f), 8'(nf));
        check("irq", 8'(q), 8'(irq));
        rd(8'h10, st);
        check("irqClr", 8'h00, 8'(irq));
    endtask : edge_scn
    task automatic print_verdict;
        if (bad_count == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict
    initial begin
        rstn = 0;
        busReq = '0;
        cmpOut = '0;
        repeat (4) @(posedge clk_sys);
        rstn <= 1;
        regs_scn();
        sel_scn();
        wr(8'h11, 8'h03);
        rd(8'h11, 8'h03);
        edge_scn(1'b1, 8'h20, 1, 0, 8'h01, 1'b1);
        rd(8'h12, 8'h01);
        edge_scn(1'b0, 8'h20, 0, 0, 8'h00, 1'b0);
        edge_scn(1'b1, 8'h10, 0, 0, 8'h00, 1'b0);
        edge_scn(1'b0, 8'h10, 0, 1, 8'h02, 1'b1);
        wr(8'h11, 8'h00);
        edge_scn(1'b1, 8'h30, 1, 0, 8'h01, 1'b0);
        print_verdict();
    end
endmodule : comparator_mode_register_tb_top
`default_nettype wire
